/* File: inc/iev_pkg.sv */
// package: register map, fields, codes and states of the interrupt enable/vector unit
package iev_pkg;
  // ==========================================
  // register byte offsets (aligned words)
  localparam logic [7:0] OFS_SERIAL_STATUS = 8'h00;
  localparam logic [7:0] OFS_DMA_STATUS = 8'h04;
  localparam logic [7:0] OFS_TIMER_STATUS = 8'h08;
  localparam logic [7:0] OFS_SERIAL_ENABLE = 8'h0c;
  localparam logic [7:0] OFS_DMA_ENABLE = 8'h10;
  localparam logic [7:0] OFS_TIMER_ENABLE = 8'h14;
  localparam logic [7:0] OFS_FIXED_VECTOR = 8'h18;
  localparam logic [7:0] OFS_MOD_VECTOR = 8'h1c;
  localparam logic [7:0] OFS_CONTROL = 8'h20;
  // ==========================================
  // field positions and masks
  localparam logic [7:0] TIMER_FIELD_MASK = 8'hf0; // bits 7..4 live, 3..0 read zero
  localparam logic [7:0] MODVEC_USER_MASK = 8'hc0; // bits 7..6 software, rest hardware
  localparam int CTL_PRIO_BIT = 7; // priority order bit
  localparam int CTL_ACK_HI = 6; // ack cycle type field msb
  localparam int CTL_ACK_LO = 5; // ack cycle type field lsb
  localparam int CTL_VSEL_BIT = 4; // vector select bit
  localparam logic [7:0] CTL_MASK = 8'hf0;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // ==========================================
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // ==========================================
  // acknowledge cycle types
  typedef enum logic [1:0] {
    ACK_NONE = 2'b00,
    ACK_SINGLE = 2'b01,
    ACK_DOUBLE = 2'b10,
    ACK_RSVD = 2'b11
  } iev_ack_t;
  // acknowledge sequencer states, gray along idle->first->wait->drive
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FIRST = 2'b01,
    ST_GAP = 2'b11,
    ST_DRIVE = 2'b10
  } iev_ackst_t;
  // ==========================================
  // hardware source codes, bits 5..0, index = source number 0..19
  localparam int NSRC = 20;
  localparam logic [5:0] SRC_CODE [NSRC] = '{
    6'h04, 6'h06, 6'h08, 6'h0a, 6'h24, 6'h26, 6'h28, 6'h2a,
    6'h14, 6'h16, 6'h18, 6'h1a, 6'h34, 6'h36, 6'h38, 6'h3a,
    6'h1c, 6'h1e, 6'h3c, 6'h3e};
endpackage : iev_pkg

/* File: design/iev_unit.sv */
// top: interrupt status, enable and vector output unit with an AXI4-Lite slave
// Operation
// - dma status bit0 shows channel0 error
// - timer status read-only, low nibble zero
// - timer status bits7..4 show timers 3..0
// - serial enable per flag, reset zero
// - serial enable bits per channel source
// - dma enable per flag, reset zero
// - dma enable bits ordered channel3 down
// - timer enable bits7..4, low nibble zero
// - vector driven on data bits 7..0
// - fixed mode outputs fixed vector unchanged
// - modified mode: two user bits, code
// - non-ack type keeps data bus released
// - single type drives vector first pulse
// - double type drives on second pulse
// - no vector when request inactive at the first ack pulse; a double cycle drives on its second pulse regardless
// - flag requests only when enabled
// - two-bit ack type field, reset none
// - vector select bit, reset fixed
// - priority bit: serial or dma first
`timescale 1ns/1ps
module iev_unit #(
  parameter int ADDR_W = 8 // bus address width
) (
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // source flags, level, held until cleared at the source
  input wire logic [7:0] serial_flags,
  input wire logic [7:0] dma_flags,
  input wire logic [3:0] timer_flags,
  // processor side
  output logic irq_n,
  input wire logic irq_ack_n,
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic [15:0] data_oe
);
  initial begin
    if (ADDR_W < 6) $error("address width too small");
  end
  // ==========================================
  // status views and request gating
  logic [7:0] serial_irq_status; // flags follow their sources
  logic [7:0] dma_irq_status;
  logic [7:0] timer_irq_status;
  logic [7:0] serial_irq_enable_r, serial_irq_enable_nxt;
  logic [7:0] dma_irq_enable_r, dma_irq_enable_nxt;
  logic [7:0] timer_irq_enable_r, timer_irq_enable_nxt;
  logic [7:0] fixed_vector_reg_r, fixed_vector_reg_nxt;
  logic [7:0] modvec_user_r, modvec_user_nxt; // bits 7..6 only
  logic [7:0] irq_control_reg_r, irq_control_reg_nxt;
  logic [19:0] pend; // enabled active sources, index = source number
  logic priority_order_bit;
  logic vector_select_bit;
  iev_pkg::iev_ack_t ack_cycle_type;
  logic [5:0] src_code; // code of winning source
  logic [7:0] modified_vector_reg;
  logic [7:0] vector_sel;
  logic unused_in;

  assign unused_in = ^data_in;
  assign serial_irq_status = serial_flags;
  assign dma_irq_status = dma_flags;
  assign timer_irq_status = {timer_flags, 4'h0};
  assign priority_order_bit = irq_control_reg_r[iev_pkg::CTL_PRIO_BIT];
  assign vector_select_bit = irq_control_reg_r[iev_pkg::CTL_VSEL_BIT];
  assign ack_cycle_type = iev_pkg::iev_ack_t'(
    irq_control_reg_r[iev_pkg::CTL_ACK_HI:iev_pkg::CTL_ACK_LO]);

  // ==========================================
  // map status bits to source numbers
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ser
      // per serial channel: rx ready, tx ready, rx status, tx status
      assign pend[gi*4+0] = serial_irq_status[gi*4+0] & serial_irq_enable_r[gi*4+0];
      assign pend[gi*4+1] = serial_irq_status[gi*4+1] & serial_irq_enable_r[gi*4+1];
      assign pend[gi*4+2] = serial_irq_status[gi*4+2] & serial_irq_enable_r[gi*4+2];
      assign pend[gi*4+3] = serial_irq_status[gi*4+3] & serial_irq_enable_r[gi*4+3];
    end
    for (gi = 0; gi < 8; gi++) begin : g_dma
      // even bit error, odd bit normal end
      assign pend[8+gi] = dma_irq_status[gi] & dma_irq_enable_r[gi];
    end
    for (gi = 0; gi < 4; gi++) begin : g_tmr
      assign pend[16+gi] = timer_irq_status[4+gi] & timer_irq_enable_r[4+gi];
    end
  endgenerate

  // ==========================================
  // priority pick: scan lowest rank first so the last hit wins
  always_comb begin
    src_code = 6'h00;
    for (int i = 19; i >= 16; i--) begin
      if (pend[i]) src_code = iev_pkg::SRC_CODE[i];
    end
    if (priority_order_bit) begin
      // dma above serial
      for (int i = 7; i >= 0; i--) if (pend[i]) src_code = iev_pkg::SRC_CODE[i];
      for (int i = 15; i >= 8; i--) if (pend[i]) src_code = iev_pkg::SRC_CODE[i];
    end else begin
      // serial above dma
      for (int i = 15; i >= 8; i--) if (pend[i]) src_code = iev_pkg::SRC_CODE[i];
      for (int i = 7; i >= 0; i--) if (pend[i]) src_code = iev_pkg::SRC_CODE[i];
    end
  end

  assign modified_vector_reg = (modvec_user_r & iev_pkg::MODVEC_USER_MASK) | {2'b00, src_code};
  assign vector_sel = vector_select_bit ? modified_vector_reg : fixed_vector_reg_r;

  // ==========================================
  // acknowledge sequencer
  iev_pkg::iev_ackst_t ack_st_r, ack_st_nxt;
  logic ack_d_r, ack_d_nxt; // previous ack level, for falling edge
  logic [7:0] vec_out_r, vec_out_nxt; // latched vector
  logic ack_fall;

  assign ack_fall = ack_d_r & ~irq_ack_n;

  // next state: count ack pulses, drive while the vector pulse is low
  always_comb begin
    ack_st_nxt = ack_st_r;
    vec_out_nxt = vec_out_r;
    ack_d_nxt = irq_ack_n;
    unique case (ack_st_r)
      iev_pkg::ST_IDLE: begin
        if (ack_fall && !irq_n) begin
          if (ack_cycle_type == iev_pkg::ACK_SINGLE) begin
            ack_st_nxt = iev_pkg::ST_DRIVE;
            vec_out_nxt = vector_sel;
          end else if (ack_cycle_type == iev_pkg::ACK_DOUBLE) begin
            ack_st_nxt = iev_pkg::ST_FIRST;
          end
        end
      end
      iev_pkg::ST_FIRST: begin
        // first pulse of a double cycle: bus stays released
        if (irq_ack_n) ack_st_nxt = iev_pkg::ST_GAP;
      end
      iev_pkg::ST_GAP: begin
        if (ack_fall) begin
          ack_st_nxt = iev_pkg::ST_DRIVE;
          vec_out_nxt = vector_sel;
        end
      end
      iev_pkg::ST_DRIVE: begin
        if (irq_ack_n) ack_st_nxt = iev_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ack_st_r <= iev_pkg::ST_IDLE;
      ack_d_r <= 1'b1;
      vec_out_r <= iev_pkg::RESET_BYTE;
    end else begin
      ack_st_r <= ack_st_nxt;
      ack_d_r <= ack_d_nxt;
      vec_out_r <= vec_out_nxt;
    end
  end

  // low byte only; high byte never driven
  assign data_out = {8'h00, vec_out_r};
  assign data_oe = {8'h00, {8{ack_st_r == iev_pkg::ST_DRIVE}}};

  // request output, registered
  logic irq_n_r, irq_n_nxt;
  always_comb irq_n_nxt = ~(|pend);
  always_ff @(posedge aclk) begin
    if (!aresetn) irq_n_r <= 1'b1;
    else irq_n_r <= irq_n_nxt;
  end
  assign irq_n = irq_n_r;

  // ==========================================
  // axi4-lite write path
  logic aw_full_r, aw_full_nxt; // address held
  logic w_full_r, w_full_nxt; // data held
  logic [ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
  logic [7:0] w_byte_r, w_byte_nxt;
  logic w_strb_r, w_strb_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic wr_go;
  logic wr_hit;
  logic [7:0] wr_ofs;

  assign s_axi_awready = ~aw_full_r & ~bvalid_r;
  assign s_axi_wready = ~w_full_r & ~bvalid_r;
  assign wr_go = aw_full_r & w_full_r & ~bvalid_r;
  assign wr_ofs = 8'(aw_addr_r);

  // decode write target
  always_comb begin
    wr_hit = 1'b1;
    unique case (wr_ofs)
      iev_pkg::OFS_SERIAL_STATUS, iev_pkg::OFS_DMA_STATUS, iev_pkg::OFS_TIMER_STATUS,
      iev_pkg::OFS_SERIAL_ENABLE, iev_pkg::OFS_DMA_ENABLE, iev_pkg::OFS_TIMER_ENABLE,
      iev_pkg::OFS_FIXED_VECTOR, iev_pkg::OFS_MOD_VECTOR, iev_pkg::OFS_CONTROL: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // write channel and register next values
  always_comb begin
    aw_full_nxt = aw_full_r;
    w_full_nxt = w_full_r;
    aw_addr_nxt = aw_addr_r;
    w_byte_nxt = w_byte_r;
    w_strb_nxt = w_strb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    serial_irq_enable_nxt = serial_irq_enable_r;
    dma_irq_enable_nxt = dma_irq_enable_r;
    timer_irq_enable_nxt = timer_irq_enable_r;
    fixed_vector_reg_nxt = fixed_vector_reg_r;
    modvec_user_nxt = modvec_user_r;
    irq_control_reg_nxt = irq_control_reg_r;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_full_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_full_nxt = 1'b1;
      w_byte_nxt = s_axi_wdata[7:0];
      w_strb_nxt = s_axi_wstrb[0];
    end
    if (wr_go) begin
      aw_full_nxt = 1'b0;
      w_full_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = wr_hit ? iev_pkg::RESP_OKAY : iev_pkg::RESP_SLVERR;
      if (w_strb_r) begin
        unique case (wr_ofs)
          iev_pkg::OFS_SERIAL_ENABLE: serial_irq_enable_nxt = w_byte_r;
          iev_pkg::OFS_DMA_ENABLE: dma_irq_enable_nxt = w_byte_r;
          iev_pkg::OFS_TIMER_ENABLE:
            timer_irq_enable_nxt = w_byte_r & iev_pkg::TIMER_FIELD_MASK;
          iev_pkg::OFS_FIXED_VECTOR: fixed_vector_reg_nxt = w_byte_r;
          iev_pkg::OFS_MOD_VECTOR: modvec_user_nxt = w_byte_r & iev_pkg::MODVEC_USER_MASK;
          iev_pkg::OFS_CONTROL: irq_control_reg_nxt = w_byte_r & iev_pkg::CTL_MASK;
          default: begin
          end
        endcase
      end
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      aw_addr_r <= '0;
      w_byte_r <= iev_pkg::RESET_BYTE;
      w_strb_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= iev_pkg::RESP_OKAY;
      serial_irq_enable_r <= iev_pkg::RESET_BYTE;
      dma_irq_enable_r <= iev_pkg::RESET_BYTE;
      timer_irq_enable_r <= iev_pkg::RESET_BYTE;
      fixed_vector_reg_r <= iev_pkg::RESET_BYTE;
      modvec_user_r <= iev_pkg::RESET_BYTE;
      irq_control_reg_r <= iev_pkg::RESET_BYTE;
    end else begin
      aw_full_r <= aw_full_nxt;
      w_full_r <= w_full_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_byte_r <= w_byte_nxt;
      w_strb_r <= w_strb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      serial_irq_enable_r <= serial_irq_enable_nxt;
      dma_irq_enable_r <= dma_irq_enable_nxt;
      timer_irq_enable_r <= timer_irq_enable_nxt;
      fixed_vector_reg_r <= fixed_vector_reg_nxt;
      modvec_user_r <= modvec_user_nxt;
      irq_control_reg_r <= irq_control_reg_nxt;
    end
  end
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // ==========================================
  // axi4-lite read path, reads have no side effect
  logic rvalid_r, rvalid_nxt;
  logic [7:0] rbyte_r, rbyte_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  assign s_axi_arready = ~rvalid_r;

  always_comb begin
    rvalid_nxt = rvalid_r;
    rbyte_nxt = rbyte_r;
    rresp_nxt = rresp_r;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = iev_pkg::RESP_OKAY;
      unique case (8'(s_axi_araddr))
        iev_pkg::OFS_SERIAL_STATUS: rbyte_nxt = serial_irq_status;
        iev_pkg::OFS_DMA_STATUS: rbyte_nxt = dma_irq_status;
        iev_pkg::OFS_TIMER_STATUS: rbyte_nxt = timer_irq_status;
        iev_pkg::OFS_SERIAL_ENABLE: rbyte_nxt = serial_irq_enable_r;
        iev_pkg::OFS_DMA_ENABLE: rbyte_nxt = dma_irq_enable_r;
        iev_pkg::OFS_TIMER_ENABLE: rbyte_nxt = timer_irq_enable_r;
        iev_pkg::OFS_FIXED_VECTOR: rbyte_nxt = fixed_vector_reg_r;
        iev_pkg::OFS_MOD_VECTOR: rbyte_nxt = modified_vector_reg;
        iev_pkg::OFS_CONTROL: rbyte_nxt = irq_control_reg_r;
        default: begin
          rbyte_nxt = iev_pkg::RESET_BYTE;
          rresp_nxt = iev_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rbyte_r <= iev_pkg::RESET_BYTE;
      rresp_r <= iev_pkg::RESP_OKAY;
    end else begin
      rvalid_r <= rvalid_nxt;
      rbyte_r <= rbyte_nxt;
      rresp_r <= rresp_nxt;
    end
  end
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = {24'h000000, rbyte_r};

  // ==========================================
  // assertions
  a_nack_released: assert property (@(posedge aclk) disable iff (!aresetn)
    (ack_cycle_type == iev_pkg::ACK_NONE && ack_st_r == iev_pkg::ST_IDLE) |=> data_oe == 16'h0000)
    else $error("bus driven in non-ack mode");
  a_single_drive: assert property (@(posedge aclk) disable iff (!aresetn)
    (ack_st_r == iev_pkg::ST_IDLE && ack_fall && !irq_n && ack_cycle_type == iev_pkg::ACK_SINGLE)
    |=> (data_oe == 16'h00ff && data_out[7:0] == $past(vector_sel)))
    else $error("single ack vector missing");
  a_double_first: assert property (@(posedge aclk) disable iff (!aresetn)
    (ack_st_r == iev_pkg::ST_IDLE && ack_fall && !irq_n && ack_cycle_type == iev_pkg::ACK_DOUBLE)
    |=> data_oe == 16'h0000 && ack_st_r == iev_pkg::ST_FIRST)
    else $error("double ack drove on first pulse");
  a_no_req_novec: assert property (@(posedge aclk) disable iff (!aresetn)
    (ack_st_r == iev_pkg::ST_IDLE && irq_n) |=> ack_st_r != iev_pkg::ST_DRIVE)
    else $error("vector output without request");
  a_high_byte: assert property (@(posedge aclk) disable iff (!aresetn)
    data_oe[15:8] == 8'h00) else $error("high data byte driven");
  a_irq_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    ((serial_flags & serial_irq_enable_r) == 8'h00 && (dma_flags & dma_irq_enable_r) == 8'h00
    && (timer_irq_status & timer_irq_enable_r) == 8'h00) |=> irq_n)
    else $error("request without enabled flag");
  a_timer_low: assert property (@(posedge aclk) disable iff (!aresetn)
    timer_irq_enable_r[3:0] == 4'h0 && timer_irq_status[3:0] == 4'h0)
    else $error("timer low nibble nonzero");
  a_modvec_code: assert property (@(posedge aclk) disable iff (!aresetn)
    (pend[8] && !priority_order_bit && pend[7:0] == 8'h00) |-> src_code == 6'h14)
    else $error("wrong source code");
endmodule : iev_unit

/* File: sim/iev_host_model.sv */
// host processor model: acknowledge pulses and the resolved low data bus
`timescale 1ns/1ps
module iev_host_model (
  input wire logic aclk,
  input wire logic [15:0] data_out,
  input wire logic [15:0] data_oe,
  output logic irq_ack_n
);
  // ==========================================
  // resolved data bus
  logic [15:0] last_r; // last level seen on the wire
  logic [15:0] bus; // wire level as the host sees it
  // released lines show the inverse of the last level, so they toggle each cycle and a stale vector shows again every second cycle
  assign bus = (data_oe & data_out) | (~data_oe & ~last_r);
  // follow the wire every cycle
  always @(posedge aclk) begin
    last_r <= bus;
  end
  // acknowledge idles high
  initial begin
    irq_ack_n = 1'b1;
    last_r = 16'h0000;
  end
  // ==========================================
  // one low acknowledge pulse, wire sampled late in the pulse
  // a double cycle is two calls, first then second pulse
  task automatic ack_pulse(output logic [7:0] vec, output logic drv, output logic hi);
    @(posedge aclk);
    irq_ack_n <= 1'b0;
    repeat (3) @(posedge aclk);
    vec = bus[7:0];
    drv = &data_oe[7:0];
    hi = |data_oe[15:8];
    irq_ack_n <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask : ack_pulse
endmodule : iev_host_model

/* File: sim/test_interrupt_enable_vector_unit.sv */
// testbench: register access, request gating and vector output of the unit
`timescale 1ns/1ps
module test_interrupt_enable_vector_unit;
  // ==========================================
  // signals
  logic aclk;
  logic aresetn;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [7:0] serial_flags, dma_flags;
  logic [3:0] timer_flags;
  logic irq_n, irq_ack_n;
  logic [15:0] data_out, data_oe;
  int fail_count = 0; // mismatches
  int num_checks = 0; // comparisons
  logic [1:0] last_bresp; // write answer taken at the bvalid handshake
  // expected hardware codes per source number
  localparam logic [5:0] src_code_exp [20] = '{6'h04, 6'h06, 6'h08, 6'h0a, 6'h24, 6'h26,
    6'h28, 6'h2a, 6'h14, 6'h16, 6'h18, 6'h1a, 6'h34, 6'h36, 6'h38, 6'h3a, 6'h1c, 6'h1e,
    6'h3c, 6'h3e};
  // ==========================================
  // instances
  iev_unit #(.ADDR_W(8)) i_iev_unit (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .serial_flags(serial_flags),
    .dma_flags(dma_flags), .timer_flags(timer_flags), .irq_n(irq_n), .irq_ack_n(irq_ack_n),
    .data_in(16'h0000), .data_out(data_out), .data_oe(data_oe));
  iev_host_model i_iev_host_model (.aclk(aclk), .data_out(data_out), .data_oe(data_oe),
    .irq_ack_n(irq_ack_n));
  // ==========================================
  // clock, 10 ns period
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // ==========================================
  // compare and report
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_word
  task automatic cmp_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_bit
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results
  // ==========================================
  // axi4-lite master: address and data offered together, each released when taken
  task automatic axi_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    last_bresp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_write
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_read
  // read a register, expect the byte and an okay answer
  task automatic chk(input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    cmp_word(d, {24'h000000, exp});
    cmp_word({30'h0, r}, {30'h0, iev_pkg::RESP_OKAY});
  endtask : chk
  // let flags and enables reach the request output
  task automatic settle;
    repeat (3) @(posedge aclk);
  endtask : settle
  // ==========================================
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    results();
  end
  // ==========================================
  // main sequence
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] vec, ofs, bitv, full;
    logic drv, hi;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h00000000;
    {timer_flags, dma_flags, serial_flags} = 20'h00000;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values of all nine places, then an unmapped one
    for (int i = 0; i < 9; i++) chk(8'(4 * i), 8'h00);
    axi_read(8'h24, d, r);
    cmp_word({30'h0, r}, {30'h0, iev_pkg::RESP_SLVERR});
    axi_write(8'h24, 8'hff);
    cmp_word({30'h0, last_bresp}, {30'h0, iev_pkg::RESP_SLVERR});
    // status follows the sources, reads and writes never clear it
    serial_flags <= 8'ha5;
    dma_flags <= 8'h01;
    timer_flags <= 4'h9;
    chk(iev_pkg::OFS_SERIAL_STATUS, 8'ha5);
    chk(iev_pkg::OFS_SERIAL_STATUS, 8'ha5);
    chk(iev_pkg::OFS_DMA_STATUS, 8'h01);
    axi_write(iev_pkg::OFS_TIMER_STATUS, 8'hff);
    cmp_word({30'h0, last_bresp}, {30'h0, iev_pkg::RESP_OKAY});
    chk(iev_pkg::OFS_TIMER_STATUS, 8'h90);
    dma_flags <= 8'h00;
    chk(iev_pkg::OFS_DMA_STATUS, 8'h00);
    {timer_flags, dma_flags, serial_flags} <= 20'h00000;
    // enables fully on, single cycle, modified vector with user bits 10
    axi_write(iev_pkg::OFS_SERIAL_ENABLE, 8'hff);
    axi_write(iev_pkg::OFS_DMA_ENABLE, 8'hff);
    axi_write(iev_pkg::OFS_TIMER_ENABLE, 8'hf0);
    axi_write(iev_pkg::OFS_MOD_VECTOR, 8'h80);
    axi_write(iev_pkg::OFS_CONTROL, 8'h30);
    chk(iev_pkg::OFS_TIMER_ENABLE, 8'hf0);
    chk(iev_pkg::OFS_CONTROL, 8'h30);
    cmp_bit(irq_n, 1'b1);
    // each source alone: gated by its own enable bit only, then its vector code
    for (int k = 0; k < 20; k++) begin
      ofs = k < 8 ? iev_pkg::OFS_SERIAL_ENABLE :
        (k < 16 ? iev_pkg::OFS_DMA_ENABLE : iev_pkg::OFS_TIMER_ENABLE);
      bitv = k < 16 ? 8'(1 << (k % 8)) : 8'(1 << (k - 12));
      full = k < 16 ? 8'hff : 8'hf0;
      {timer_flags, dma_flags, serial_flags} <= 20'(1 << k);
      axi_write(ofs, full & ~bitv);
      settle();
      cmp_bit(irq_n, 1'b1);
      axi_write(ofs, full);
      settle();
      cmp_bit(irq_n, 1'b0);
      chk(iev_pkg::OFS_MOD_VECTOR, 8'h80 | {2'b00, src_code_exp[k]});
      i_iev_host_model.ack_pulse(vec, drv, hi);
      cmp_bit(drv, 1'b1);
      cmp_bit(hi, 1'b0);
      cmp_word({24'h0, vec}, {24'h0, 8'h80 | {2'b00, src_code_exp[k]}});
    end
    // several at once: priority order bit swaps serial and dma, timers last
    {timer_flags, dma_flags, serial_flags} <= {4'h1, 8'h01, 8'h0a};
    chk(iev_pkg::OFS_MOD_VECTOR, 8'h86);
    axi_write(iev_pkg::OFS_CONTROL, 8'hb0);
    chk(iev_pkg::OFS_MOD_VECTOR, 8'h94);
    i_iev_host_model.ack_pulse(vec, drv, hi);
    cmp_word({24'h0, vec}, 32'h00000094);
    {timer_flags, dma_flags, serial_flags} <= {4'h1, 8'h80, 8'h00};
    chk(iev_pkg::OFS_MOD_VECTOR, 8'hba);
    // fixed vector under each cycle type: none, single, double, reserved
    axi_write(iev_pkg::OFS_FIXED_VECTOR, 8'h5c);
    for (int m = 0; m < 4; m++) begin
      axi_write(iev_pkg::OFS_CONTROL, 8'(m << 5));
      chk(iev_pkg::OFS_CONTROL, 8'(m << 5));
      i_iev_host_model.ack_pulse(vec, drv, hi);
      cmp_bit(drv, m == 1);
      if (m == 2) i_iev_host_model.ack_pulse(vec, drv, hi);
      if (m == 2) cmp_bit(drv, 1'b1);
      if (m == 1 || m == 2) cmp_word({24'h0, vec}, 32'h0000005c);
    end
    // no request pending: acknowledge gets no vector
    axi_write(iev_pkg::OFS_CONTROL, 8'h20);
    {timer_flags, dma_flags, serial_flags} <= 20'h00000;
    settle();
    cmp_bit(irq_n, 1'b1);
    i_iev_host_model.ack_pulse(vec, drv, hi);
    cmp_bit(drv, 1'b0);
    results();
  end
endmodule : test_interrupt_enable_vector_unit
